// file: core/txcfg_pkg.sv
// package: hardware configuration register map, fields, tables and carrier types
package txcfg_pkg;

   localparam logic [7:0]  HWCFG_OFFSET     = 8'h74;
   localparam int          STRAP_BIT        = 24;
   localparam int          MODE_BIT         = 21;
   localparam int          SF_BIT           = 20;
   localparam int          SIZE_LSB         = 16;
   localparam int          LEVEL_LSB        = 12;
   localparam logic        MODE_RESET       = 1'h0;
   localparam logic        SF_RESET         = 1'h0;
   localparam logic [3:0]  SIZE_RESET       = 4'h5;
   localparam logic [1:0]  LEVEL_RESET      = 2'h0;
   localparam logic [3:0]  SIZE_MAX_KB      = 4'hE;
   localparam logic [14:0] KB_BYTES         = 15'h0400;
   localparam logic [14:0] STATUS_FIFO_BYTES = 15'h0200;
   localparam logic [14:0] MEM_TOTAL_BYTES  = 15'h4000;

   // threshold in dwords, indexed by level code; slow table when mode is set
   localparam logic [7:0] THR_SLOW [4] = '{8'h12, 8'h18, 8'h20, 8'h28};
   localparam logic [7:0] THR_FAST [4] = '{8'h20, 8'h30, 8'h40, 8'h50};

   typedef struct packed {
      logic        wr;
      logic        rd;
      logic [7:0]  addr;
      logic [31:0] wdata;
   } txcfg_req_t;

   typedef struct packed {
      logic [14:0] tx_total_bytes;
      logic [14:0] tx_status_bytes;
      logic [14:0] tx_data_bytes;
      logic [14:0] rx_total_bytes;
   } txcfg_alloc_t;

endpackage

// file: core/txcfg_top.sv
// module: hardware configuration register with transmit start and underrun logic
//
// Behaviour
// - bit 24 reads crossover strap pin, read-only
// - mode bit picks threshold table, ignored when store_forward
// - store_forward waits for whole frame before start
// - cut-through starts early using mode and level
// - cut-through starvation reports transmit underrun
// - tx fifo size in kilobytes, at most fourteen
// - 512 bytes status fifo, rest data fifo
// - receive fifos get 16KB minus transmit size
// - level used only cut-through; start at threshold
`timescale 1ns/10ps
`default_nettype none

module txcfg_top (
   input  wire logic                   clk,
   input  wire logic                   rst,
   input  wire txcfg_pkg::txcfg_req_t  req,
   output logic [31:0]                 rdata_q,
   input  wire logic                   crossover_auto_strap,
   input  wire logic [11:0]            buffered_dwords,
   input  wire logic                   frame_complete,
   input  wire logic                   mac_dword_req,
   input  wire logic                   mac_frame_done,
   output logic                        tx_start_q,
   output logic                        tx_busy_q,
   output logic                        underrun_q,
   output logic [7:0]                  threshold_q,
   output txcfg_pkg::txcfg_alloc_t     alloc_q
);

   typedef enum logic [0:0] {TXCFG_IDLE, TXCFG_SEND} txcfg_state_t;

   logic                    mode_q, mode_d;
   logic                    sf_q, sf_d;
   logic [3:0]              size_q, size_d;
   logic [1:0]              level_q, level_d;
   logic [31:0]             rdata_d;
   logic                    hit_wr, hit_rd;
   txcfg_state_t            state_q, state_d;
   logic                    tx_start_d, underrun_d, tx_busy_d;
   logic [7:0]              threshold_d;
   txcfg_pkg::txcfg_alloc_t alloc_d;
   logic [3:0]              size_eff;

   ////////////////////////////////////////////////////////////////////////////
   // register access

   assign hit_wr = req.wr && (req.addr == txcfg_pkg::HWCFG_OFFSET);
   assign hit_rd = req.rd && (req.addr == txcfg_pkg::HWCFG_OFFSET);

   always_comb begin
      mode_d  = mode_q;
      sf_d    = sf_q;
      size_d  = size_q;
      level_d = level_q;
      rdata_d = rdata_q;
      if (hit_wr) begin
         // only writable fields are taken, reserved and strap bits dropped
         mode_d  = req.wdata[txcfg_pkg::MODE_BIT];
         sf_d    = req.wdata[txcfg_pkg::SF_BIT];
         size_d  = req.wdata[txcfg_pkg::SIZE_LSB +: 4];
         level_d = req.wdata[txcfg_pkg::LEVEL_LSB +: 2];
      end
      if (hit_rd) begin
         rdata_d = 32'h0000_0000;
         rdata_d[txcfg_pkg::STRAP_BIT] = crossover_auto_strap;
         rdata_d[txcfg_pkg::MODE_BIT] = mode_q;
         rdata_d[txcfg_pkg::SF_BIT] = sf_q;
         rdata_d[txcfg_pkg::SIZE_LSB +: 4] = size_q;
         rdata_d[txcfg_pkg::LEVEL_LSB +: 2] = level_q;
      end else if (req.rd) begin
         rdata_d = 32'h0000_0000;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         mode_q  <= txcfg_pkg::MODE_RESET;
         sf_q    <= txcfg_pkg::SF_RESET;
         size_q  <= txcfg_pkg::SIZE_RESET;
         level_q <= txcfg_pkg::LEVEL_RESET;
         rdata_q <= 32'h0000_0000;
      end else begin
         mode_q  <= mode_d;
         sf_q    <= sf_d;
         size_q  <= size_d;
         level_q <= level_d;
         rdata_q <= rdata_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // memory split and threshold selection

   assign size_eff = (size_q > txcfg_pkg::SIZE_MAX_KB) ? txcfg_pkg::SIZE_MAX_KB : size_q;

   always_comb begin
      alloc_d.tx_total_bytes  = 15'(size_eff * txcfg_pkg::KB_BYTES);
      alloc_d.tx_status_bytes = txcfg_pkg::STATUS_FIFO_BYTES;
      alloc_d.tx_data_bytes   = alloc_d.tx_total_bytes - txcfg_pkg::STATUS_FIFO_BYTES;
      alloc_d.rx_total_bytes  = txcfg_pkg::MEM_TOTAL_BYTES - alloc_d.tx_total_bytes;
      threshold_d = mode_q ? txcfg_pkg::THR_SLOW[level_q]
                           : txcfg_pkg::THR_FAST[level_q];
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         // start from the table entry of the reset fields so no false start follows reset
         alloc_q     <= '0;
         threshold_q <= txcfg_pkg::MODE_RESET ? txcfg_pkg::THR_SLOW[txcfg_pkg::LEVEL_RESET]
                                              : txcfg_pkg::THR_FAST[txcfg_pkg::LEVEL_RESET];
      end else begin
         alloc_q     <= alloc_d;
         threshold_q <= threshold_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // transmit start and underrun

   always_comb begin
      state_d    = state_q;
      tx_start_d = 1'b0;
      underrun_d = 1'b0;
      case (state_q)
         TXCFG_IDLE: begin
            if (sf_q) begin
               tx_start_d = frame_complete;
            end else begin
               tx_start_d = frame_complete ||
                            (buffered_dwords >= {4'h0, threshold_q});
            end
            if (tx_start_d) begin
               state_d = TXCFG_SEND;
            end
         end
         TXCFG_SEND: begin
            underrun_d = !sf_q && mac_dword_req && !frame_complete &&
                         (buffered_dwords == 12'h000);
            if (mac_frame_done) begin
               state_d = TXCFG_IDLE;
            end
         end
         default: begin
            state_d = TXCFG_IDLE;
         end
      endcase
      tx_busy_d = (state_d == TXCFG_SEND);
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         state_q    <= TXCFG_IDLE;
         tx_start_q <= 1'b0;
         underrun_q <= 1'b0;
         tx_busy_q  <= 1'b0;
      end else begin
         state_q    <= state_d;
         tx_start_q <= tx_start_d;
         underrun_q <= underrun_d;
         tx_busy_q  <= tx_busy_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // assertions

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);

   sequence s_cfg_read;
      req.rd && (req.addr == txcfg_pkg::HWCFG_OFFSET);
   endsequence

   sequence s_sf_idle_complete;
      (state_q == TXCFG_IDLE) && sf_q && frame_complete;
   endsequence

   AST_STRAP: assert property (s_cfg_read |=>
      rdata_q[24] == $past(crossover_auto_strap))
      else $error("strap bit does not follow pin");

   AST_RSVD: assert property (s_cfg_read |=>
      (rdata_q[31:25] == 7'h00) && (rdata_q[23:22] == 2'h0) && (rdata_q[15:14] == 2'h0)
      && (rdata_q[11:0] == 12'h000))
      else $error("reserved bits not zero");

   AST_SF_START: assert property ((state_q == TXCFG_IDLE) && sf_q && !frame_complete
      |=> !tx_start_q)
      else $error("store and forward started early");

   AST_SF_GO: assert property (s_sf_idle_complete |=> tx_start_q && tx_busy_q)
      else $error("store and forward did not start");

   AST_CT_START: assert property ((state_q == TXCFG_IDLE) && !sf_q &&
      (buffered_dwords >= {4'h0, threshold_q}) |=> tx_start_q && tx_busy_q)
      else $error("cut-through did not start at threshold");

   AST_CT_HOLD: assert property ((state_q == TXCFG_IDLE) && !sf_q && !frame_complete &&
      (buffered_dwords < {4'h0, threshold_q}) |=> !tx_start_q)
      else $error("cut-through started below threshold");

   AST_THR: assert property (!$past(rst) |=> threshold_q == ($past(mode_q) ?
      txcfg_pkg::THR_SLOW[$past(level_q)] : txcfg_pkg::THR_FAST[$past(level_q)]))
      else $error("wrong threshold table entry");

   AST_UNDERRUN: assert property (underrun_q |-> !$past(sf_q) &&
      $past(buffered_dwords) == 12'h000 && $past(mac_dword_req) && $past(state_q) == TXCFG_SEND)
      else $error("underrun without starvation");

   AST_SPLIT: assert property (!$past(rst) |->
      (alloc_q.tx_data_bytes + 15'h0200 == alloc_q.tx_total_bytes) &&
      (alloc_q.tx_status_bytes == 15'h0200) &&
      (alloc_q.rx_total_bytes + alloc_q.tx_total_bytes == 15'h4000))
      else $error("fifo memory split wrong");

   AST_SIZE: assert property ($stable(size_q) |=> alloc_q.tx_total_bytes <= 15'h3800)
      else $error("transmit allocation above 14KB");

endmodule

`default_nettype wire

// file: bench/tb_tx_threshold_fifo_alloc_cfg.sv
// testbench: register access, threshold tables, transmit start and underrun
`timescale 1ns/10ps
`default_nettype none

module tb_tx_threshold_fifo_alloc_cfg;
   logic                    clk = 1'h0;
   logic                    rst = 1'h1;
   txcfg_pkg::txcfg_req_t   req = '0;
   logic [31:0]             rdata_q;
   logic                    strap = 1'h0;
   logic [11:0]             buf_dw = '0;
   logic                    fr_cmp = 1'h0;
   logic                    dw_req = 1'h0;
   logic                    fr_done = 1'h0;
   logic                    start;
   logic                    busy;
   logic                    undr;
   logic [7:0]              thr;
   txcfg_pkg::txcfg_alloc_t alloc;
   int                      error_cnt = 0;
   int                      checks = 0;
   logic [7:0]              tbl [8] = '{8'h20, 8'h30, 8'h40, 8'h50, 8'h12, 8'h18, 8'h20, 8'h28};

   always #50 clk = ~clk;

   txcfg_top u_dut (
      .clk                  (clk),
      .rst                  (rst),
      .req                  (req),
      .rdata_q              (rdata_q),
      .crossover_auto_strap (strap),
      .buffered_dwords      (buf_dw),
      .frame_complete       (fr_cmp),
      .mac_dword_req        (dw_req),
      .mac_frame_done       (fr_done),
      .tx_start_q           (start),
      .tx_busy_q            (busy),
      .underrun_q           (undr),
      .threshold_q          (thr),
      .alloc_q              (alloc)
   );

   ////////////////////////////////////////////////////////////////////////////
   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("mismatch %s expected %h seen %h", nm, exp, got);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      req <= '{wr: 1'h1, rd: 1'h0, addr: a, wdata: d};
      @(posedge clk);
      req <= '0;
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      @(posedge clk);
      req <= '{wr: 1'h0, rd: 1'h1, addr: a, wdata: '0};
      @(posedge clk);
      req <= '0;
      @(negedge clk);
      chk("rdata", exp, rdata_q);
   endtask

   task automatic chk_alloc(input logic [14:0] tx);
      repeat (2) @(posedge clk);
      @(negedge clk);
      chk("tx_total", 32'(tx), 32'(alloc.tx_total_bytes));
      chk("tx_status", 32'h200, 32'(alloc.tx_status_bytes));
      chk("tx_data", 32'(tx - 15'h0200), 32'(alloc.tx_data_bytes));
      chk("rx_total", 32'(15'h4000 - tx), 32'(alloc.rx_total_bytes));
   endtask

   task automatic obs(input int n, input logic s, input logic u);
      repeat (n) begin
         @(negedge clk);
         chk("tx_start", 32'(s), 32'(start));
         chk("underrun", 32'(u), 32'(undr));
      end
   endtask

   task automatic complete_run;
      $display("checks %0d error_cnt %0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////////
   initial begin
      #200000;
      error_cnt++;
      complete_run();
   end

   initial begin
      repeat (2) @(posedge clk);
      rst <= 1'h0;
      strap <= 1'h1;
      rd(8'h74, 32'h0105_0000);
      chk_alloc(15'h1400);
      wr(8'h74, 32'hFFFF_FFFF);
      strap <= 1'h0;
      rd(8'h74, 32'h003F_3000);
      chk_alloc(15'h3800);
      wr(8'h70, 32'h0000_0000);
      rd(8'h74, 32'h003F_3000);
      rd(8'h70, 32'h0000_0000);
      for (int i = 0; i < 8; i++) begin
         wr(8'h74, {10'h000, i[2], 1'h0, 4'h5, 2'h0, i[1:0], 12'h000});
         repeat (2) @(posedge clk);
         @(negedge clk);
         chk("threshold", 32'(tbl[i]), 32'(thr));
      end
      wr(8'h74, 32'h0005_0000);
      buf_dw <= 12'h01F;
      obs(4, 1'h0, 1'h0);
      @(posedge clk);
      buf_dw <= 12'h020;
      @(posedge clk);
      obs(1, 1'h1, 1'h0);
      chk("tx_busy", 32'h1, 32'(busy));
      obs(2, 1'h0, 1'h0);
      @(posedge clk);
      buf_dw <= '0;
      dw_req <= 1'h1;
      @(posedge clk);
      dw_req <= 1'h0;
      obs(1, 1'h0, 1'h1);
      obs(1, 1'h0, 1'h0);
      @(posedge clk);
      fr_done <= 1'h1;
      @(posedge clk);
      fr_done <= 1'h0;
      @(negedge clk);
      chk("tx_busy", 32'h0, 32'(busy));
      wr(8'h74, 32'h0035_3000);
      buf_dw <= 12'hFFF;
      obs(4, 1'h0, 1'h0);
      @(posedge clk);
      fr_cmp <= 1'h1;
      @(posedge clk);
      obs(1, 1'h1, 1'h0);
      @(posedge clk);
      fr_cmp <= 1'h0;
      buf_dw <= '0;
      dw_req <= 1'h1;
      @(posedge clk);
      obs(2, 1'h0, 1'h0);
      complete_run();
   end
endmodule

`default_nettype wire
